// ### common/pdrh_defs.svh
// constants for the programmable divider with clear and freeze
`ifndef PDRH_DEFS_SVH
`define PDRH_DEFS_SVH
`define PDRH_RATIO_W    32
`define PDRH_RATIO_LSB  0
`define PDRH_SYNC_RST   1'b0
`define PDRH_POS_RST    1'b0
`define PDRH_NEG_RST    1'b1
`define PDRH_SYNC_STAGES 2
`endif

// ### common/pdrh_pkg.sv
// types for the programmable divider with clear and freeze
`include "pdrh_defs.svh"
package pdrh_pkg;
   typedef logic [`PDRH_RATIO_W-1:0] pdrh_ratio_t;
   typedef struct packed
   {
      logic dividerClear;
      logic outputFreeze;
   } pdrh_ctrl_s;
   typedef struct packed
   {
      logic outPos;
      logic outNeg;
   } pdrh_out_s;
endpackage

// ### hw/pdrh_sync2.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`include "pdrh_defs.svh"
module pdrh_sync2 #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         stage1_reg <= {W{`PDRH_SYNC_RST}};
         stage2_reg <= {W{`PDRH_SYNC_RST}};
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule

// ### hw/pdrh_divider.sv
// divider core with clear, freeze and ratio dependent pulse width
`timescale 1ns/1ps
`include "pdrh_defs.svh"
module pdrh_divider
   import pdrh_pkg::*;
#(
   parameter int RATIO_W = `PDRH_RATIO_W
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire pdrh_ctrl_s         ctrlIn,
   input  wire logic [RATIO_W-1:0] ratioBits,
   output pdrh_out_s               divOut
);
   //----------------------------------------------------------------
   // input synchronisers
   //----------------------------------------------------------------
   logic [RATIO_W+1:0] syncVec;
   logic               clearSync;
   logic               freezeSync;
   logic [RATIO_W-1:0] ratioSync;
   logic [RATIO_W-1:0] ratio;

   pdrh_sync2 #(.W(RATIO_W + 2)) uSync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn ({ctrlIn.dividerClear, ctrlIn.outputFreeze, ratioBits}),
      .syncOut (syncVec)
   );

   // level 1 enables, 0 disables; undriven pins are not pulled low and pass through the synchroniser as z
   assign clearSync  = syncVec[RATIO_W+1];
   assign freezeSync = syncVec[RATIO_W];
   assign ratioSync  = syncVec[`PDRH_RATIO_LSB +: RATIO_W];

   //----------------------------------------------------------------
   // ratio acceptance
   //----------------------------------------------------------------
   // word taken once two edges agree, so skewed bits never mix
   logic [RATIO_W-1:0] ratioSeen_reg;
   logic [RATIO_W-1:0] ratio_reg;
   logic [RATIO_W-1:0] ratio_next;
   logic               ratioSettled;

   assign ratioSettled = (ratioSync == ratioSeen_reg);
   assign ratio_next   = ratioSettled ? ratioSync : ratio_reg;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ratioSeen_reg <= '0;
         ratio_reg     <= '0;
      end
      else
      begin
         ratioSeen_reg <= ratioSync;
         ratio_reg     <= ratio_next;
      end
   end

   assign ratio = ratio_reg;

   //----------------------------------------------------------------
   // pulse width
   //----------------------------------------------------------------
   function automatic logic [RATIO_W-1:0] widthOf(input logic [RATIO_W-1:0] n);
      logic [RATIO_W+1:0] twoN;
      logic [RATIO_W+1:0] p;
      logic [RATIO_W+1:0] pick;
      twoN = {1'b0, n, 1'b0};
      pick = '0;
      for (int i = 0; i < RATIO_W; i++)
      begin
         p = (RATIO_W + 2)'(1) << i;
         if ((p + (p << 1)) <= twoN)
         begin
            pick = p;
         end
      end
      widthOf = n - pick[RATIO_W-1:0];
   endfunction

   logic [RATIO_W-1:0] pulseWidth;
   assign pulseWidth = widthOf(ratio);

   //----------------------------------------------------------------
   // counter and outputs
   //----------------------------------------------------------------
   logic [RATIO_W-1:0] cnt_reg;
   logic [RATIO_W-1:0] cnt_next;
   logic               outPos_reg;
   logic               outPos_next;
   logic               outNeg_reg;
   logic               outNeg_next;
   logic               atEnd;
   logic               inPulse;

   assign atEnd    = (ratio == '0) || (cnt_reg >= ratio - RATIO_W'(1));
   assign inPulse  = (cnt_reg < pulseWidth);
   assign cnt_next = clearSync ? '0 :
                     atEnd ? '0 : cnt_reg + RATIO_W'(1);
   assign outPos_next = clearSync  ? `PDRH_POS_RST :
                        (freezeSync || ratio == '0) ? outPos_reg : inPulse;
   assign outNeg_next = clearSync  ? `PDRH_NEG_RST :
                        (freezeSync || ratio == '0) ? outNeg_reg : !inPulse;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg    <= '0;
         outPos_reg <= `PDRH_POS_RST;
         outNeg_reg <= `PDRH_NEG_RST;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         outPos_reg <= outPos_next;
         outNeg_reg <= outNeg_next;
      end
   end

   assign divOut.outPos = outPos_reg;
   assign divOut.outNeg = outNeg_reg;

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   property p_clear_state;
      @(posedge ref_clk) disable iff (rst)
      clearSync |=> (cnt_reg == '0);
   endproperty
   a_clear_state: assert property (p_clear_state)
      else $error("counter not cleared");

   property p_clear_out;
      @(posedge ref_clk) disable iff (rst)
      clearSync [*2] |-> ##1 (!divOut.outPos && divOut.outNeg);
   endproperty
   a_clear_out: assert property (p_clear_out)
      else $error("clear output levels wrong");

   property p_freeze_hold;
      @(posedge ref_clk) disable iff (rst)
      (freezeSync && !clearSync) |=> $stable(divOut);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold)
      else $error("outputs moved during freeze");

   property p_freeze_count;
      @(posedge ref_clk) disable iff (rst)
      (freezeSync && !clearSync && ratio > 1 && cnt_reg == '0 && $stable(ratio))
         |=> (cnt_reg == RATIO_W'(1));
   endproperty
   a_freeze_count: assert property (p_freeze_count)
      else $error("counter stopped during freeze");

   property p_complement;
      @(posedge ref_clk) disable iff (rst)
      (!freezeSync && ratio != '0) |=> (divOut.outPos != divOut.outNeg);
   endproperty
   a_complement: assert property (p_complement)
      else $error("outputs not complementary");

   property p_wrap;
      @(posedge ref_clk) disable iff (rst)
      (!clearSync && ratio != '0 && cnt_reg == ratio - RATIO_W'(1)) |=> (cnt_reg == '0);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("period not equal to ratio");

   property p_duty;
      @(posedge ref_clk) disable iff (rst)
      (ratio >= 2) |-> ((RATIO_W + 2)'(pulseWidth) * 3 >= (RATIO_W + 2)'(ratio))
         && ((RATIO_W + 2)'(pulseWidth) * 3 <= (RATIO_W + 2)'(ratio) * 2)
         && ((ratio & (ratio - RATIO_W'(1))) != '0
             || (RATIO_W + 2)'(pulseWidth) * 2 == (RATIO_W + 2)'(ratio));
   endproperty
   a_duty: assert property (p_duty)
      else $error("duty cycle out of range");

   property p_table12;
      @(posedge ref_clk) disable iff (rst)
      (ratio == RATIO_W'(12) && !clearSync && !freezeSync
         && (cnt_reg == RATIO_W'(3) || cnt_reg == RATIO_W'(4)))
         |=> (divOut.outPos == ($past(cnt_reg) == RATIO_W'(3)));
   endproperty
   a_table12: assert property (p_table12)
      else $error("pulse width wrong for twelve");

   property p_width9;
      @(posedge ref_clk) disable iff (rst)
      (ratio == RATIO_W'(9)) |-> (pulseWidth == RATIO_W'(5));
   endproperty
   a_width9: assert property (p_width9)
      else $error("pulse width wrong for nine");

   c_clear:  cover property (@(posedge ref_clk) disable iff (rst) clearSync ##1 !clearSync);
   c_freeze: cover property (@(posedge ref_clk) disable iff (rst)
                             freezeSync && cnt_reg == ratio - RATIO_W'(1));
   c_wrap:   cover property (@(posedge ref_clk) disable iff (rst)
                             ratio == RATIO_W'(7) && cnt_reg == RATIO_W'(6));
   c_ratio_zero: cover property (@(posedge ref_clk) disable iff (rst)
                                 freezeSync && ratio == '0);
endmodule

// ### sim/pdrh_host.sv
// host model driving ratio, clear and freeze
`timescale 1ns/1ps
module pdrh_host
   import pdrh_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire pdrh_ratio_t reqRatio,
   input  wire pdrh_ctrl_s  reqCtrl,
   output pdrh_ratio_t      ratioOut,
   output pdrh_ctrl_s       ctrlOut
);
   // ----------------------------------------
   // pins change just after the rising edge
   // ----------------------------------------
   initial ratioOut = '0;
   initial ctrlOut = '0;
   always @(posedge ref_clk)
   begin
      ratioOut <= #1 reqRatio;
      ctrlOut.dividerClear <= #1 reqCtrl.dividerClear;
      ctrlOut.outputFreeze <= #1 reqCtrl.outputFreeze | (reqRatio == '0);
   end
endmodule

// ### sim/programmable_divider_reset_hold_bench.sv
// self-checking bench for the divider core
`timescale 1ns/1ps
module programmable_divider_reset_hold_bench
   import pdrh_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   pdrh_ratio_t reqRatio = 32'h0;
   pdrh_ratio_t ratioBits;
   pdrh_ctrl_s  reqCtrl = 2'h0;
   pdrh_ctrl_s  ctrlIn;
   pdrh_out_s   divOut;
   pdrh_out_s   held;
   int          errors = 0;
   int          checks_done = 0;
   int          hi;
   int          rises;
   logic        prev;
   int          rowN [15] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};
   int          rowW [15] = '{1, 1, 2, 3, 2, 3, 4, 5, 6, 7, 4, 5, 6, 7, 8};
   always #50 ref_clk = ~ref_clk;
   pdrh_host i_host (.ref_clk(ref_clk), .reqRatio(reqRatio), .reqCtrl(reqCtrl),
                     .ratioOut(ratioBits), .ctrlOut(ctrlIn));
   pdrh_divider i_dut (.ref_clk(ref_clk), .rst(rst), .ctrlIn(ctrlIn), .ratioBits(ratioBits),
                       .divOut(divOut));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      if (errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task measure(input int n, input int w);
      hi = 0;
      rises = 0;
      tick(3 * n + 8);
      prev = divOut.outPos;
      for (int i = 0; i < 3 * n; i++)
      begin
         tick(1);
         check(32'(divOut.outNeg), 32'(!divOut.outPos));
         if (i < n && divOut.outPos === 1'b1) hi++;
         if (prev === 1'b0 && divOut.outPos === 1'b1) rises++;
         prev = divOut.outPos;
      end
      check(32'(hi), 32'(w));
      check(32'(rises), 32'h3);
   endtask
   task hold_check(input int n);
      for (int i = 0; i < n; i++)
      begin
         tick(1);
         check(32'(divOut), 32'(held));
      end
   endtask
   // ----------------------------------------
   // table rows, then awkward cases
   // ----------------------------------------
   initial
   begin
      tick(6);
      check(32'(divOut), 32'h1);
      rst = 1'b0;
      for (int r = 0; r < 15; r++)
      begin
         reqRatio = 32'(rowN[r]);
         measure(rowN[r], rowW[r]);
      end
      reqCtrl.dividerClear = 1'b1;
      tick(4);
      held = 2'h1;
      hold_check(12);
      reqCtrl.dividerClear = 1'b0;
      measure(16, 8);
      reqCtrl.outputFreeze = 1'b1;
      tick(4);
      held = divOut;
      hold_check(13);
      reqRatio = 32'h0;
      hold_check(10);
      reqRatio = 32'h5;
      tick(4);
      reqCtrl.outputFreeze = 1'b0;
      measure(5, 3);
      rst = 1'b1;
      tick(2);
      check(32'(divOut), 32'h1);
      rst = 1'b0;
      measure(5, 3);
      test_done();
   end
endmodule
